// ---- irq_mask_pkg.sv ----
// Purpose: constants for the interrupt enable mask bank
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: offsets of the mask words and of the status/mask pair are local
package irq_mask_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_MASK_WORD0 = 12'h000;
  localparam logic [11:0] OFF_MASK_WORD1 = 12'h004;
  localparam logic [11:0] OFF_MASK_WORD2 = 12'h008;
  localparam logic [11:0] OFF_PEND_WORD0 = 12'h010;
  localparam logic [11:0] OFF_PEND_WORD1 = 12'h014;
  localparam logic [11:0] OFF_PEND_WORD2 = 12'h018;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h020;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h024;
  // implemented bits of each word; word0 holds only its low three bits here
  localparam logic [15:0] IMPL_WORD0 = 16'h0007;
  localparam logic [15:0] IMPL_WORD1 = 16'hfffb;
  localparam logic [15:0] IMPL_WORD2 = 16'hdfff;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [1:0] EVT_RESET = 2'h0;
  // event bits: 0 gated request rose, 1 unmapped access
  localparam int unsigned EVT_ROSE = 0;
  localparam int unsigned EVT_BADADDR = 1;
endpackage

// ---- irq_mask_bank.sv ----
// Purpose: software-writable interrupt enable masks gating pending flags
// Assumes: pending flags come from logic on clk_sys_i
// Notes: slave answers in the access phase with no wait states
`timescale 1ns/1ns

// Functional notes
// - mask bit one forwards its source request, zero blocks it
// - implemented bits of words 1 and 2 are read/write, reset to zero
// - word 1 bit 2 has no storage, reads zero, ignores writes
// - word 2 bit 13 has no storage, reads zero, ignores writes
// - word 1 bits 15..8: uart2 tx/rx, pin2, timer5/4, cmp4/3, dma2
// - word 1 bits 7..0: cap8, cap7, adc2, pin1, pin change, -, i2c1
// - word 2 bits 15..8: timer6, dma4, -, cmp8..cmp5, cap6
// - word 2 bits 7..0: cap5..3, dma3, can1 event/rx, spi2 event/error
// - word 0 bits 2,1,0 gate compare 1, capture 1, pin 0
// - each source has a pending flag, one once its request occurred
module irq_mask_bank (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [15:0] pend_word0_i,
  input wire logic [15:0] pend_word1_i,
  input wire logic [15:0] pend_word2_i,
  output logic [15:0] req_word0_o,
  output logic [15:0] req_word1_o,
  output logic [15:0] req_word2_o,
  output logic irq_o
);

  // ==========================================================
  // register state
  logic [15:0] irq_mask_word0;
  logic [15:0] irq_mask_word1;
  logic [15:0] irq_mask_word2;
  logic [15:0] next_irq_mask_word0;
  logic [15:0] next_irq_mask_word1;
  logic [15:0] next_irq_mask_word2;
  logic [1:0] evt_status;
  logic [1:0] evt_mask;
  logic [1:0] next_evt_status;
  logic [1:0] next_evt_mask;
  logic [15:0] req0;
  logic [15:0] req1;
  logic [15:0] req2;
  logic [15:0] next_req0;
  logic [15:0] next_req1;
  logic [15:0] next_req2;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic access;
  logic wr;
  logic hit;
  logic [15:0] wmask;
  logic any_rise;
  logic [15:0] rise0;
  logic [15:0] rise1;
  logic [15:0] rise2;
  logic clr_status;

  // named views of the enables that the next edge will hold
  logic cmp1_mask;
  logic cap1_mask;
  logic extpin0_mask;
  logic uart2_tx_mask;
  logic uart2_rx_mask;
  logic extpin2_mask;
  logic timer5_mask;
  logic timer4_mask;
  logic cmp4_mask;
  logic cmp3_mask;
  logic dma_ch2_done_mask;
  logic cap8_mask;
  logic cap7_mask;
  logic adc2_done_mask;
  logic extpin1_mask;
  logic pin_change_mask;
  logic i2c1_master_mask;
  logic i2c1_slave_mask;
  logic timer6_mask;
  logic dma_ch4_done_mask;
  logic [3:0] cmp8_5_mask;
  logic cap6_mask;
  logic [2:0] cap5_3_mask;
  logic dma_ch3_done_mask;
  logic can1_event_mask;
  logic can1_rx_ready_mask;
  logic spi2_event_mask;
  logic spi2_error_mask;

  assign cmp1_mask = next_irq_mask_word0[2];
  assign cap1_mask = next_irq_mask_word0[1];
  assign extpin0_mask = next_irq_mask_word0[0];
  assign uart2_tx_mask = next_irq_mask_word1[15];
  assign uart2_rx_mask = next_irq_mask_word1[14];
  assign extpin2_mask = next_irq_mask_word1[13];
  assign timer5_mask = next_irq_mask_word1[12];
  assign timer4_mask = next_irq_mask_word1[11];
  assign cmp4_mask = next_irq_mask_word1[10];
  assign cmp3_mask = next_irq_mask_word1[9];
  assign dma_ch2_done_mask = next_irq_mask_word1[8];
  assign cap8_mask = next_irq_mask_word1[7];
  assign cap7_mask = next_irq_mask_word1[6];
  assign adc2_done_mask = next_irq_mask_word1[5];
  assign extpin1_mask = next_irq_mask_word1[4];
  assign pin_change_mask = next_irq_mask_word1[3];
  assign i2c1_master_mask = next_irq_mask_word1[1];
  assign i2c1_slave_mask = next_irq_mask_word1[0];
  assign timer6_mask = next_irq_mask_word2[15];
  assign dma_ch4_done_mask = next_irq_mask_word2[14];
  assign cmp8_5_mask = next_irq_mask_word2[12:9];
  assign cap6_mask = next_irq_mask_word2[8];
  assign cap5_3_mask = next_irq_mask_word2[7:5];
  assign dma_ch3_done_mask = next_irq_mask_word2[4];
  assign can1_event_mask = next_irq_mask_word2[3];
  assign can1_rx_ready_mask = next_irq_mask_word2[2];
  assign spi2_event_mask = next_irq_mask_word2[1];
  assign spi2_error_mask = next_irq_mask_word2[0];

  // ==========================================================
  // apb decode
  assign access = psel_i & penable_i;
  assign wr = access & pwrite_i;
  assign wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  assign pready_o = 1'b1;

  always_comb begin
    unique case (paddr_i)
      irq_mask_pkg::OFF_MASK_WORD0,
      irq_mask_pkg::OFF_MASK_WORD1,
      irq_mask_pkg::OFF_MASK_WORD2,
      irq_mask_pkg::OFF_PEND_WORD0,
      irq_mask_pkg::OFF_PEND_WORD1,
      irq_mask_pkg::OFF_PEND_WORD2,
      irq_mask_pkg::OFF_IRQ_STATUS,
      irq_mask_pkg::OFF_IRQ_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr_o = access & ~hit;

  // ==========================================================
  // mask words
  always_comb begin
    next_irq_mask_word0 = irq_mask_word0;
    next_irq_mask_word1 = irq_mask_word1;
    next_irq_mask_word2 = irq_mask_word2;
    next_evt_mask = evt_mask;
    if (wr) begin
      // unimplemented positions are dropped by the impl masks
      unique case (paddr_i)
        irq_mask_pkg::OFF_MASK_WORD0: begin
          next_irq_mask_word0 = ((irq_mask_word0 & ~wmask) | (pwdata_i[15:0] & wmask))
                                & irq_mask_pkg::IMPL_WORD0;
        end
        irq_mask_pkg::OFF_MASK_WORD1: begin
          next_irq_mask_word1 = ((irq_mask_word1 & ~wmask) | (pwdata_i[15:0] & wmask))
                                & irq_mask_pkg::IMPL_WORD1;
        end
        irq_mask_pkg::OFF_MASK_WORD2: begin
          next_irq_mask_word2 = ((irq_mask_word2 & ~wmask) | (pwdata_i[15:0] & wmask))
                                & irq_mask_pkg::IMPL_WORD2;
        end
        irq_mask_pkg::OFF_IRQ_MASK: begin
          if (pstrb_i[0]) begin
            next_evt_mask = pwdata_i[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // gated requests, registered so a write is seen at the next edge
  // one enable per source, so a write never disturbs a neighbour
  always_comb begin
    next_req0 = 16'h0000;
    next_req1 = 16'h0000;
    next_req2 = 16'h0000;
    // word0: bits above 2 are not held by this block
    next_req0[2] = pend_word0_i[2] & cmp1_mask;
    next_req0[1] = pend_word0_i[1] & cap1_mask;
    next_req0[0] = pend_word0_i[0] & extpin0_mask;
    // word1: bit 2 has no enable and stays blocked
    next_req1[15] = pend_word1_i[15] & uart2_tx_mask;
    next_req1[14] = pend_word1_i[14] & uart2_rx_mask;
    next_req1[13] = pend_word1_i[13] & extpin2_mask;
    next_req1[12] = pend_word1_i[12] & timer5_mask;
    next_req1[11] = pend_word1_i[11] & timer4_mask;
    next_req1[10] = pend_word1_i[10] & cmp4_mask;
    next_req1[9] = pend_word1_i[9] & cmp3_mask;
    next_req1[8] = pend_word1_i[8] & dma_ch2_done_mask;
    next_req1[7] = pend_word1_i[7] & cap8_mask;
    next_req1[6] = pend_word1_i[6] & cap7_mask;
    next_req1[5] = pend_word1_i[5] & adc2_done_mask;
    next_req1[4] = pend_word1_i[4] & extpin1_mask;
    next_req1[3] = pend_word1_i[3] & pin_change_mask;
    next_req1[1] = pend_word1_i[1] & i2c1_master_mask;
    next_req1[0] = pend_word1_i[0] & i2c1_slave_mask;
    // word2: bit 13 has no enable and stays blocked
    next_req2[15] = pend_word2_i[15] & timer6_mask;
    next_req2[14] = pend_word2_i[14] & dma_ch4_done_mask;
    next_req2[12] = pend_word2_i[12] & cmp8_5_mask[3];
    next_req2[11] = pend_word2_i[11] & cmp8_5_mask[2];
    next_req2[10] = pend_word2_i[10] & cmp8_5_mask[1];
    next_req2[9] = pend_word2_i[9] & cmp8_5_mask[0];
    next_req2[8] = pend_word2_i[8] & cap6_mask;
    next_req2[7] = pend_word2_i[7] & cap5_3_mask[2];
    next_req2[6] = pend_word2_i[6] & cap5_3_mask[1];
    next_req2[5] = pend_word2_i[5] & cap5_3_mask[0];
    next_req2[4] = pend_word2_i[4] & dma_ch3_done_mask;
    next_req2[3] = pend_word2_i[3] & can1_event_mask;
    next_req2[2] = pend_word2_i[2] & can1_rx_ready_mask;
    next_req2[1] = pend_word2_i[1] & spi2_event_mask;
    next_req2[0] = pend_word2_i[0] & spi2_error_mask;
  end
  assign req_word0_o = req0;
  assign req_word1_o = req1;
  assign req_word2_o = req2;
  // flop outputs keep unchanged sources free of glitches
  assign rise0 = next_req0 & ~req0;
  assign rise1 = next_req1 & ~req1;
  assign rise2 = next_req2 & ~req2;
  assign any_rise = |{rise0, rise1, rise2};

  // ==========================================================
  // block events: set wins over write-one-to-clear
  // an event landing with the clear is kept, so none is ever lost
  assign clr_status = wr && paddr_i == irq_mask_pkg::OFF_IRQ_STATUS && pstrb_i[0];
  always_comb begin
    next_evt_status = evt_status;
    if (clr_status) begin
      next_evt_status = evt_status & ~pwdata_i[1:0];
    end
    if (any_rise) begin
      next_evt_status[irq_mask_pkg::EVT_ROSE] = 1'b1;
    end
    if (access && !hit) begin
      next_evt_status[irq_mask_pkg::EVT_BADADDR] = 1'b1;
    end
  end
  assign irq_o = |(evt_status & evt_mask);

  // ==========================================================
  // read data
  // captured in setup so the word stands through the whole access phase
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        irq_mask_pkg::OFF_MASK_WORD0: next_rdata = {16'h0000, irq_mask_word0};
        irq_mask_pkg::OFF_MASK_WORD1: next_rdata = {16'h0000, irq_mask_word1};
        irq_mask_pkg::OFF_MASK_WORD2: next_rdata = {16'h0000, irq_mask_word2};
        irq_mask_pkg::OFF_PEND_WORD0: next_rdata = {16'h0000, pend_word0_i};
        irq_mask_pkg::OFF_PEND_WORD1: next_rdata = {16'h0000, pend_word1_i};
        irq_mask_pkg::OFF_PEND_WORD2: next_rdata = {16'h0000, pend_word2_i};
        irq_mask_pkg::OFF_IRQ_STATUS: next_rdata = {30'h0000_0000, evt_status};
        irq_mask_pkg::OFF_IRQ_MASK: next_rdata = {30'h0000_0000, evt_mask};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end
  assign prdata_o = rdata;

  // ==========================================================
  // registers
  // reset holds every request low so nothing leaks out during reset
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_mask_word0 <= irq_mask_pkg::MASK_RESET;
      irq_mask_word1 <= irq_mask_pkg::MASK_RESET;
      irq_mask_word2 <= irq_mask_pkg::MASK_RESET;
      evt_status <= irq_mask_pkg::EVT_RESET;
      evt_mask <= irq_mask_pkg::EVT_RESET;
      req0 <= irq_mask_pkg::MASK_RESET;
      req1 <= irq_mask_pkg::MASK_RESET;
      req2 <= irq_mask_pkg::MASK_RESET;
      rdata <= 32'h0000_0000;
    end else begin
      irq_mask_word0 <= next_irq_mask_word0;
      irq_mask_word1 <= next_irq_mask_word1;
      irq_mask_word2 <= next_irq_mask_word2;
      evt_status <= next_evt_status;
      evt_mask <= next_evt_mask;
      req0 <= next_req0;
      req1 <= next_req1;
      req2 <= next_req2;
      rdata <= next_rdata;
    end
  end

endmodule

// ---- pend_src.sv ----
// Purpose: model of peripheral request sources with sticky pending flags
// Assumes: set pulses come from the bench on clk_i
// Notes: flags are never touched by the mask bank
`timescale 1ns/1ns
module pend_src (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [47:0] set_i,
  output logic [47:0] pend_o
);
  logic [47:0] next_pend;
  // ====
  // sticky flags
  always_comb begin
    next_pend = pend_o | set_i;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_o <= '0;
    end else begin
      pend_o <= next_pend;
    end
  end
endmodule

// ---- irq_mask_bank_checker.sv ----
// Purpose: port checker for irq_mask_bank
// Assumes: masks shadowed from apb writes with byte strobes
// Notes: gated requests lag pending flags by one edge
`timescale 1ns/1ns
module irq_mask_bank_checker (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [15:0] pend_word0_i,
  input wire logic [15:0] pend_word1_i,
  input wire logic [15:0] pend_word2_i,
  input wire logic [15:0] req_word0_o,
  input wire logic [15:0] req_word1_o,
  input wire logic [15:0] req_word2_o,
  input wire logic irq_o
);
  logic [15:0] m0, m1, m2, next_m0, next_m1, next_m2, be;
  logic wr, rdx;
  function automatic logic [15:0] upd(logic [15:0] m, logic [15:0] impl, logic [11:0] a);
    return (wr && paddr_i == a) ? ((m & ~be) | (pwdata_i[15:0] & be)) & impl : m;
  endfunction
  // ====
  // shadow of the mask words
  always_comb begin
    wr = psel_i && penable_i && pwrite_i;
    rdx = psel_i && penable_i && !pwrite_i;
    be = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    next_m0 = upd(m0, irq_mask_pkg::IMPL_WORD0, irq_mask_pkg::OFF_MASK_WORD0);
    next_m1 = upd(m1, irq_mask_pkg::IMPL_WORD1, irq_mask_pkg::OFF_MASK_WORD1);
    next_m2 = upd(m2, irq_mask_pkg::IMPL_WORD2, irq_mask_pkg::OFF_MASK_WORD2);
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      m0 <= '0;
      m1 <= '0;
      m2 <= '0;
    end else begin
      m0 <= next_m0;
      m1 <= next_m1;
      m2 <= next_m2;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // ====
  // properties
  property p_req0; req_word0_o == ($past(pend_word0_i) & m0); endproperty
  a_req0: assert property (p_req0) else $error("word0 request wrong");
  property p_req1; req_word1_o == ($past(pend_word1_i) & m1); endproperty
  a_req1: assert property (p_req1) else $error("word1 request wrong");
  property p_req2; req_word2_o == ($past(pend_word2_i) & m2); endproperty
  a_req2: assert property (p_req2) else $error("word2 request wrong");
  property p_rd1; rdx && paddr_i == irq_mask_pkg::OFF_MASK_WORD1 |-> prdata_o == {16'h0000, m1};
  endproperty
  a_rd1: assert property (p_rd1) else $error("word1 read wrong");
  property p_rd2; rdx && paddr_i == irq_mask_pkg::OFF_MASK_WORD2 |-> prdata_o == {16'h0000, m2};
  endproperty
  a_rd2: assert property (p_rd2) else $error("word2 read wrong");
  property p_stab; $stable(pend_word1_i) && !wr |=> $stable(req_word1_o); endproperty
  a_stab: assert property (p_stab) else $error("request moved");
  property p_rst; $rose(rst_b_i) |-> (req_word1_o | req_word2_o) == 16'h0000 && !irq_o;
  endproperty
  a_rst: assert property (p_rst) else $error("not clear after reset");
  property p_hole; !req_word1_o[2] && !req_word2_o[13] && req_word0_o[15:3] == 13'h0000;
  endproperty
  a_hole: assert property (p_hole) else $error("unbacked bit active");
endmodule
bind irq_mask_bank irq_mask_bank_checker chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .pend_word0_i(pend_word0_i), .pend_word1_i(pend_word1_i),
  .pend_word2_i(pend_word2_i), .req_word0_o(req_word0_o), .req_word1_o(req_word1_o),
  .req_word2_o(req_word2_o), .irq_o(irq_o));

// ---- testbench.sv ----
// Purpose: self-checking bench for irq_mask_bank
// Assumes: apb slave, pending flags from pend_src
// Notes: a mid-run reset repeats the reset checks
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = '0, rd, prdata;
  logic [3:0] pstrb = 4'h0;
  logic [47:0] set = '0, pend;
  logic [15:0] req0, req1, req2;
  int n_fail = 0, checked = 0, k;
  always #50 clk = ~clk;
  pend_src src (.clk_i(clk), .rst_b_i(rst_b), .set_i(set), .pend_o(pend));
  irq_mask_bank dut (.clk_sys_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pend_word0_i(pend[15:0]),
    .pend_word1_i(pend[31:16]), .pend_word2_i(pend[47:32]), .req_word0_o(req0),
    .req_word1_o(req1), .req_word2_o(req2), .irq_o(irq));
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic rdy;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, rd, exp);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ====
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (k = 0; k < 2; k++) begin
      rchk("mask1", irq_mask_pkg::OFF_MASK_WORD1, 32'h0);
      rchk("mask2", irq_mask_pkg::OFF_MASK_WORD2, 32'h0);
      apb(1'b1, irq_mask_pkg::OFF_MASK_WORD0, 32'hffffffff, 4'hf);
      apb(1'b1, irq_mask_pkg::OFF_MASK_WORD1, 32'hffffffff, 4'hf);
      apb(1'b1, irq_mask_pkg::OFF_MASK_WORD2, 32'hffffffff, 4'hf);
      rchk("mask0", irq_mask_pkg::OFF_MASK_WORD0, 32'h00000007);
      rchk("mask1", irq_mask_pkg::OFF_MASK_WORD1, 32'h0000fffb);
      rchk("mask2", irq_mask_pkg::OFF_MASK_WORD2, 32'h0000dfff);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
    end
    apb(1'b1, irq_mask_pkg::OFF_MASK_WORD1, 32'hffffffff, 4'h1);
    rchk("lane0", irq_mask_pkg::OFF_MASK_WORD1, 32'h000000fb);
    set <= '1;
    @(posedge clk);
    set <= '0;
    for (k = 0; k < 16; k++) begin
      apb(1'b1, irq_mask_pkg::OFF_MASK_WORD1, 32'h1 << k, 4'h3);
      apb(1'b1, irq_mask_pkg::OFF_MASK_WORD2, 32'h1 << k, 4'h3);
      repeat (2) @(negedge clk);
      chk("req1", {16'h0, req1}, (32'h1 << k) & 32'hfffb);
      chk("req2", {16'h0, req2}, (32'h1 << k) & 32'hdfff);
    end
    apb(1'b1, irq_mask_pkg::OFF_MASK_WORD0, 32'h5, 4'h3);
    apb(1'b1, irq_mask_pkg::OFF_MASK_WORD1, 32'h0, 4'h3);
    repeat (2) @(negedge clk);
    chk("req0", {16'h0, req0}, 32'h5);
    chk("req1", {16'h0, req1}, 32'h0);
    rchk("pend1", irq_mask_pkg::OFF_PEND_WORD1, 32'h0000ffff);
    // unmapped access raises the masked error event
    rchk("hole", 12'h00c, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    @(negedge clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, irq_mask_pkg::OFF_IRQ_MASK, 32'h2, 4'hf);
    repeat (2) @(negedge clk);
    chk("irq on", {31'h0, irq}, 32'h1);
    rchk("status", irq_mask_pkg::OFF_IRQ_STATUS, 32'h3);
    rchk("evt mask", irq_mask_pkg::OFF_IRQ_MASK, 32'h2);
    apb(1'b1, irq_mask_pkg::OFF_IRQ_STATUS, 32'h3, 4'hf);
    repeat (2) @(negedge clk);
    chk("irq off", {31'h0, irq}, 32'h0);
    rchk("status clr", irq_mask_pkg::OFF_IRQ_STATUS, 32'h0);
    // a fresh enable on a pending source raises the rise event
    apb(1'b1, irq_mask_pkg::OFF_IRQ_MASK, 32'h1, 4'hf);
    apb(1'b1, irq_mask_pkg::OFF_MASK_WORD1, 32'h1, 4'h3);
    repeat (2) @(negedge clk);
    chk("irq rise", {31'h0, irq}, 32'h1);
    chk("req1 rise", {16'h0, req1}, 32'h1);
    give_verdict();
  end
  initial begin
    #2000000;
    n_fail++;
    give_verdict();
  end
endmodule
